// ### common/hspc_pkg.sv
//==============================================================================
// Contract
// - Linear mode counts between limits; crossing one flags under/overflow and halts.
// - Ring mode increment past ring maximum wraps to 0 and continues upward.
// - Ring mode decrement below 0 loads ring maximum and continues downward.
// - Ring mode never flags under/overflow; count stays in 0 to ring maximum.
// - Ring maximum is 32-bit unsigned, loaded at startup or by runtime command.
// - Ring maximum of zero behaves as FFFF FFFF hex.
// - Ring maximum change refused while a comparison runs on that counter.
// - Comparison refused to start if any table entry exceeds ring maximum.
// - Accepted ring maximum change clears the count value to 0.
// - Reset forces count to 0; per counter choose index+software or software only; the code's index method clears on index only, with no software clear.
// - Index method: count clears on index rising while armed reset bit is set.
// - Reset bit level is sampled only at scan start; arming starts next cycle.
// - Software method: off-to-on of reset bit at scan start clears count then.
// - Per counter option: reset stops comparison or lets it continue from zero.
// - Each I/O refresh copies every count into upper and lower 16-bit words.
// - Each interrupt input event latches the count for later reading.
// - Counter 0 alone measures input frequency in hertz as a 32-bit value.
// - Frequency ranges to 0003 0D40 hex differential, 0001 86A0 hex otherwise.
// - Frequency above the mode maximum saturates at that maximum.
// - Frequency measurement runs alongside counting without disturbing it.
// - Counter 0 converts frequency to r/min or count to revolutions via pulses/rev.
// - Increment mode counts only rising edges of one input, never decrements.
//==============================================================================
package hspc_pkg;

    localparam int unsigned NUM_CNT = 4;
    localparam int unsigned CNT_W   = 32;
    localparam int unsigned HALF_W  = 16;

    // Input decoding methods
    localparam logic [1:0] MODE_INCREMENT = 2'h0;
    localparam logic [1:0] MODE_DIFF_4X   = 2'h1;
    localparam logic [1:0] MODE_UP_DOWN   = 2'h2;
    localparam logic [1:0] MODE_PULSE_DIR = 2'h3;

    // Linear range as signed 32-bit limits
    localparam logic [31:0] LIN_LOWER = 32'h8000_0000;
    localparam logic [31:0] LIN_UPPER = 32'h7FFF_FFFF;

    localparam logic [31:0] RING_MAX_RESET = 32'h0000_0000;
    localparam logic [31:0] RING_MAX_FULL  = 32'hFFFF_FFFF;
    localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;

    localparam logic [31:0] FREQ_MAX_DIFF  = 32'h0003_0D40;
    localparam logic [31:0] FREQ_MAX_OTHER = 32'h0001_86A0;

    localparam logic [31:0] SEC_PER_MIN = 32'h0000_003C;

    // Frequency gate time: one second
    localparam longint unsigned CLK_HZ         = 10_000_000;
    localparam longint unsigned FREQ_WINDOW_MS = 1000;
    localparam longint unsigned FREQ_WINDOW_CYC = (CLK_HZ * FREQ_WINDOW_MS) / 1000;

    localparam logic [5:0] DIV_STEPS = 6'h20;

    typedef struct packed {
        logic       ring_mode;
        logic       reset_sw_only;
        logic [1:0] input_mode;
        logic       cmp_continue;
    } hspc_cfg_type;

    typedef struct packed {
        logic overflow;
        logic underflow;
        logic cmp_active;
        logic index_armed;
        logic count_up;
    } hspc_stat_type;

    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
    } hspc_words_type;

endpackage : hspc_pkg

// ### logic/hspc_counter.sv
`timescale 1ns/1ps
module hspc_counter #(
    parameter int unsigned  N_CNT         = 4,
    parameter int unsigned  WINDOW_CYCLES = 10_000_000
) (
    // Clock and reset
    input  wire logic                                  CLK,
    input  wire logic                                  RST_N,
    // Encoder pins (asynchronous)
    input  wire logic [N_CNT-1:0]                      PHASE_A,
    input  wire logic [N_CNT-1:0]                      PHASE_B,
    input  wire logic [N_CNT-1:0]                      INDEX_Z,
    input  wire logic [N_CNT-1:0]                      INT_IN,
    // Controller timing
    input  wire logic                                  SCAN_START,
    input  wire logic                                  IO_REFRESH,
    // Configuration and reset bits
    input  wire hspc_pkg::hspc_cfg_type [N_CNT-1:0]    CFG,
    input  wire logic [N_CNT-1:0]                      COUNTER_RESET_BITS,
    // Ring maximum load
    input  wire logic [N_CNT-1:0]                      RING_MAX_WR,
    input  wire logic [31:0]                           RING_MAX_DATA,
    output logic [N_CNT-1:0][31:0]                     RING_MAX,
    output logic                                       RING_MAX_REFUSED,
    // Count write
    input  wire logic [N_CNT-1:0]                      COUNT_WR,
    input  wire logic [31:0]                           COUNT_WR_DATA,
    // Comparison control
    input  wire logic [N_CNT-1:0]                      CMP_START,
    input  wire logic [N_CNT-1:0]                      CMP_STOP,
    input  wire logic [31:0]                           CMP_TABLE_MAX,
    output logic                                       CMP_REFUSED,
    // Count readout
    output hspc_pkg::hspc_words_type [N_CNT-1:0]       COUNT_WORDS,
    output hspc_pkg::hspc_words_type [N_CNT-1:0]       LATCHED_WORDS,
    input  wire logic                                  PV_RD_REQ,
    input  wire logic [1:0]                            PV_RD_SEL,
    output logic [31:0]                                PV_RD_DATA,
    output logic                                       PV_RD_ACK,
    output hspc_pkg::hspc_stat_type [N_CNT-1:0]        STATUS,
    // Frequency and rotation (counter 0)
    input  wire logic                                  FREQ_REQ,
    output logic [31:0]                                FREQ_DATA,
    output logic                                       FREQ_ACK,
    input  wire logic                                  ROT_REQ,
    input  wire logic                                  ROT_TOTAL,
    input  wire logic [31:0]                           PULSES_PER_ROT,
    output logic [31:0]                                ROT_DATA,
    output logic                                       ROT_DONE,
    output logic                                       ROT_BUSY
);
    import hspc_pkg::*;

    //==========================================================================
    // Reset release and pin synchronisers
    //==========================================================================
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Stages 0 and 1 synchronise, stage 2 is the previous value for edges
    logic [N_CNT-1:0] a_s0_q, a_s1_q, a_s2_q;
    logic [N_CNT-1:0] b_s0_q, b_s1_q, b_s2_q;
    logic [N_CNT-1:0] z_s0_q, z_s1_q, z_s2_q;
    logic [N_CNT-1:0] i_s0_q, i_s1_q, i_s2_q;

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {a_s0_q, a_s1_q, a_s2_q} <= '0;
            {b_s0_q, b_s1_q, b_s2_q} <= '0;
            {z_s0_q, z_s1_q, z_s2_q} <= '0;
            {i_s0_q, i_s1_q, i_s2_q} <= '0;
        end
        else
        begin
            a_s0_q <= PHASE_A;
            a_s1_q <= a_s0_q;
            a_s2_q <= a_s1_q;
            b_s0_q <= PHASE_B;
            b_s1_q <= b_s0_q;
            b_s2_q <= b_s1_q;
            z_s0_q <= INDEX_Z;
            z_s1_q <= z_s0_q;
            z_s2_q <= z_s1_q;
            i_s0_q <= INT_IN;
            i_s1_q <= i_s0_q;
            i_s2_q <= i_s1_q;
        end
    end

    //==========================================================================
    // Input decoding: returns {up, down}
    //==========================================================================
    function automatic logic [1:0] hspc_decode(input logic [1:0] mode,
                                               input logic a_old, input logic a_new,
                                               input logic b_old, input logic b_new);
        logic a_rise;
        logic b_rise;
        logic a_chg;
        logic b_chg;
        a_rise = !a_old && a_new;
        b_rise = !b_old && b_new;
        a_chg  = a_old ^ a_new;
        b_chg  = b_old ^ b_new;
        case (mode)
            MODE_INCREMENT: hspc_decode = {a_rise, 1'b0};
            MODE_DIFF_4X:
                if (a_chg && !b_chg)
                    hspc_decode = (a_new ^ b_new) ? 2'h2 : 2'h1;
                else if (b_chg && !a_chg)
                    hspc_decode = (a_new ^ b_new) ? 2'h1 : 2'h2;
                else
                    hspc_decode = 2'h0;
            // A is the up pulse, B the down pulse; both at once cancel
            MODE_UP_DOWN:   hspc_decode = (a_rise && b_rise) ? 2'h0 : {a_rise, b_rise};
            MODE_PULSE_DIR: hspc_decode = {a_rise && b_new, a_rise && !b_new};
            default:        hspc_decode = 2'h0;
        endcase
    endfunction : hspc_decode

    //==========================================================================
    // Per-counter logic
    //==========================================================================
    logic [N_CNT-1:0][31:0] count_q;
    logic [N_CNT-1:0][31:0] ring_max_q;
    logic [N_CNT-1:0]       rst_bit_q;
    logic [N_CNT-1:0]       cmp_active_q;
    logic [N_CNT-1:0]       ovf_q;
    logic [N_CNT-1:0]       unf_q;
    logic [N_CNT-1:0]       dir_up_q;
    logic [N_CNT-1:0]       ring_refused;
    logic [N_CNT-1:0]       cmp_refused;
    logic [N_CNT-1:0]       up_ev;

    genvar g;
    generate
        for (g = 0; g < N_CNT; g++)
        begin : g_cnt
            logic [1:0]  step;
            logic [31:0] eff_max;
            logic        sw_clear;
            logic        idx_clear;
            logic        clear;
            logic        ring_ok;

            assign step      = hspc_decode(CFG[g].input_mode, a_s2_q[g], a_s1_q[g],
                                           b_s2_q[g], b_s1_q[g]);
            assign up_ev[g]  = step[1];
            assign eff_max   = (ring_max_q[g] == RING_MAX_RESET) ?
                               RING_MAX_FULL : ring_max_q[g];
            assign sw_clear  = CFG[g].reset_sw_only && SCAN_START &&
                               COUNTER_RESET_BITS[g] && !rst_bit_q[g];
            assign idx_clear = !CFG[g].reset_sw_only && rst_bit_q[g] &&
                               z_s1_q[g] && !z_s2_q[g];
            assign clear     = sw_clear || idx_clear;
            assign ring_ok   = RING_MAX_WR[g] && !cmp_active_q[g];
            assign ring_refused[g] = RING_MAX_WR[g] && cmp_active_q[g];
            assign cmp_refused[g]  = CMP_START[g] && CFG[g].ring_mode &&
                                     (CMP_TABLE_MAX > eff_max);

            // Reset bit level is only looked at when a scan begins
            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                    rst_bit_q[g] <= 1'b0;
                else if (SCAN_START)
                    rst_bit_q[g] <= COUNTER_RESET_BITS[g];
            end

            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                    ring_max_q[g] <= RING_MAX_RESET;
                else if (ring_ok)
                    ring_max_q[g] <= RING_MAX_DATA;
            end

            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                    cmp_active_q[g] <= 1'b0;
                else if (CMP_STOP[g])
                    cmp_active_q[g] <= 1'b0;
                else if (CMP_START[g] && !cmp_refused[g])
                    cmp_active_q[g] <= 1'b1;
                else if (clear && !CFG[g].cmp_continue)
                    cmp_active_q[g] <= 1'b0;
            end

            // Direction follows the last decoded edge
            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                    dir_up_q[g] <= 1'b1;
                else if (step[1] || step[0])
                    dir_up_q[g] <= step[1];
            end

            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    count_q[g] <= COUNT_RESET;
                    ovf_q[g]   <= 1'b0;
                    unf_q[g]   <= 1'b0;
                end
                else if (clear || ring_ok)
                begin
                    count_q[g] <= COUNT_RESET;
                    ovf_q[g]   <= 1'b0;
                    unf_q[g]   <= 1'b0;
                end
                else if (COUNT_WR[g])
                begin
                    count_q[g] <= COUNT_WR_DATA;
                    ovf_q[g]   <= 1'b0;
                    unf_q[g]   <= 1'b0;
                end
                else if (CFG[g].ring_mode)
                begin
                    ovf_q[g] <= 1'b0;
                    unf_q[g] <= 1'b0;
                    if (step[1])
                        count_q[g] <= (count_q[g] >= eff_max) ?
                                      COUNT_RESET : count_q[g] + 32'h1;
                    else if (step[0])
                        count_q[g] <= (count_q[g] == COUNT_RESET) ?
                                      eff_max : count_q[g] - 32'h1;
                end
                else if (!ovf_q[g] && !unf_q[g])
                begin
                    if (step[1])
                    begin
                        if (count_q[g] == LIN_UPPER)
                            ovf_q[g] <= 1'b1;
                        else
                            count_q[g] <= count_q[g] + 32'h1;
                    end
                    else if (step[0])
                    begin
                        if (count_q[g] == LIN_LOWER)
                            unf_q[g] <= 1'b1;
                        else
                            count_q[g] <= count_q[g] - 32'h1;
                    end
                end
            end

            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                    COUNT_WORDS[g] <= '0;
                else if (IO_REFRESH)
                    COUNT_WORDS[g] <= {count_q[g][31:16], count_q[g][15:0]};
            end

            // Interrupt input edge captures the count before the task runs
            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                    LATCHED_WORDS[g] <= '0;
                else if (i_s1_q[g] && !i_s2_q[g])
                    LATCHED_WORDS[g] <= {count_q[g][31:16], count_q[g][15:0]};
            end

            assign RING_MAX[g] = ring_max_q[g];
            assign STATUS[g]   = '{overflow: ovf_q[g], underflow: unf_q[g],
                                   cmp_active: cmp_active_q[g],
                                   index_armed: rst_bit_q[g] && !CFG[g].reset_sw_only,
                                   count_up: dir_up_q[g]};
        end
    endgenerate

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            RING_MAX_REFUSED <= 1'b0;
            CMP_REFUSED      <= 1'b0;
        end
        else
        begin
            RING_MAX_REFUSED <= |ring_refused;
            CMP_REFUSED      <= |cmp_refused;
        end
    end

    //==========================================================================
    // On-demand count read
    //==========================================================================
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            PV_RD_DATA <= '0;
            PV_RD_ACK  <= 1'b0;
        end
        else
        begin
            PV_RD_ACK <= PV_RD_REQ;
            if (PV_RD_REQ)
                PV_RD_DATA <= count_q[PV_RD_SEL];
        end
    end

    //==========================================================================
    // Frequency measurement, counter 0 only
    //==========================================================================
    // Counts up-edges over a one second gate from its own taps of the decoded
    // steps, so the counting path itself carries no extra load.
    logic [31:0] win_cnt_q;
    logic [31:0] edge_cnt_q;
    logic [31:0] freq_q;
    logic [31:0] freq_max;

    assign freq_max = (CFG[0].input_mode == MODE_DIFF_4X) ?
                      FREQ_MAX_DIFF : FREQ_MAX_OTHER;

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_cnt_q  <= '0;
            edge_cnt_q <= '0;
            freq_q     <= '0;
        end
        else if (win_cnt_q == WINDOW_CYCLES - 1)
        begin
            win_cnt_q  <= '0;
            edge_cnt_q <= '0;
            freq_q     <= (edge_cnt_q > freq_max) ? freq_max : edge_cnt_q;
        end
        else
        begin
            win_cnt_q <= win_cnt_q + 32'h1;
            if (up_ev[0] && edge_cnt_q != RING_MAX_FULL)
                edge_cnt_q <= edge_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            FREQ_DATA <= '0;
            FREQ_ACK  <= 1'b0;
        end
        else
        begin
            FREQ_ACK <= FREQ_REQ;
            if (FREQ_REQ)
                FREQ_DATA <= freq_q;
        end
    end

    //==========================================================================
    // Rotation conversion by serial division
    //==========================================================================
    // One quotient bit per cycle keeps the divider small; a result takes
    // 33 cycles, which is far below any scan time.
    typedef enum logic {DIV_IDLE, DIV_RUN} hspc_div_type;

    hspc_div_type div_state_q;
    logic [63:0]  rpm_product;
    logic [32:0]  rem_q;
    logic [31:0]  quo_q;
    logic [31:0]  divisor_q;
    logic [5:0]   step_q;
    logic [32:0]  rem_shift;

    assign rpm_product = freq_q * SEC_PER_MIN;
    assign rem_shift   = {rem_q[31:0], quo_q[31]};

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_state_q <= DIV_IDLE;
            rem_q       <= '0;
            quo_q       <= '0;
            divisor_q   <= '0;
            step_q      <= '0;
            ROT_DATA    <= '0;
            ROT_DONE    <= 1'b0;
        end
        else
        begin
            ROT_DONE <= 1'b0;
            case (div_state_q)
                DIV_IDLE:
                    if (ROT_REQ)
                    begin
                        rem_q       <= '0;
                        quo_q       <= ROT_TOTAL ? count_q[0] : rpm_product[31:0];
                        divisor_q   <= PULSES_PER_ROT;
                        step_q      <= '0;
                        div_state_q <= DIV_RUN;
                    end
                DIV_RUN:
                    if (step_q == DIV_STEPS)
                    begin
                        ROT_DATA    <= (divisor_q == '0) ? RING_MAX_FULL : quo_q;
                        ROT_DONE    <= 1'b1;
                        div_state_q <= DIV_IDLE;
                    end
                    else
                    begin
                        step_q <= step_q + 6'h1;
                        if (rem_shift >= {1'b0, divisor_q})
                        begin
                            rem_q <= rem_shift - {1'b0, divisor_q};
                            quo_q <= {quo_q[30:0], 1'b1};
                        end
                        else
                        begin
                            rem_q <= rem_shift;
                            quo_q <= {quo_q[30:0], 1'b0};
                        end
                    end
                default: div_state_q <= DIV_IDLE;
            endcase
        end
    end

    assign ROT_BUSY = (div_state_q == DIV_RUN);

endmodule : hspc_counter

// ### verification/hspc_pulse_src.sv
`timescale 1ns/1ps
// ====================
// Pulse plus direction source on counter 0
module hspc_pulse_src (
    // Clock and pins
    input logic CLK,
    output logic [3:0] PHASE_A,
    output logic [3:0] PHASE_B
);
    initial {PHASE_A, PHASE_B} = 8'h00;
    // Three cycles per level keeps every pin level above the two-cycle minimum
    task automatic run(input int n, input logic up);
        @(posedge CLK) PHASE_B[0] <= up;
        repeat (n)
        begin
            repeat (3) @(posedge CLK);
            PHASE_A[0] <= 1'h1;
            repeat (3) @(posedge CLK);
            PHASE_A[0] <= 1'h0;
        end
    endtask : run
endmodule : hspc_pulse_src

// ### verification/hspc_counter_assertions.sv
`timescale 1ns/1ps
// ====================
// Counter 0 port checks
module hspc_counter_assertions #(
    parameter int unsigned N_CNT = 4
) (
    // Clock, reset and controls
    input logic CLK,
    input logic RST_N,
    input hspc_pkg::hspc_cfg_type [N_CNT-1:0] CFG,
    input logic [N_CNT-1:0] COUNT_WR,
    input logic SCAN_START,
    input logic [N_CNT-1:0] RING_MAX_WR,
    input logic [31:0] RING_MAX_DATA,
    input logic [N_CNT-1:0] CMP_START,
    input logic [N_CNT-1:0] CMP_STOP,
    input logic [31:0] CMP_TABLE_MAX,
    input logic ROT_REQ,
    // Observed outputs
    input logic [N_CNT-1:0][31:0] RING_MAX,
    input logic RING_MAX_REFUSED,
    input logic CMP_REFUSED,
    input hspc_pkg::hspc_stat_type [N_CNT-1:0] STATUS,
    input logic FREQ_ACK,
    input logic [31:0] FREQ_DATA,
    input logic ROT_BUSY,
    input logic ROT_DONE
);
    import hspc_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic [31:0] eff_max;
    // A stored zero stands for the full 32-bit range
    assign eff_max = (RING_MAX[0] == 32'h0) ? RING_MAX_FULL : RING_MAX[0];
    sequence rot_run; ROT_BUSY [*8] ##25 ROT_BUSY ##1 ROT_DONE; endsequence
    ring_take_a: assert property (RING_MAX_WR[0] && !STATUS[0].cmp_active |=>
        RING_MAX[0] == $past(RING_MAX_DATA) && !RING_MAX_REFUSED) else $error("ring max lost");
    ring_refuse_a: assert property (RING_MAX_WR[0] && STATUS[0].cmp_active |=>
        RING_MAX_REFUSED && $stable(RING_MAX[0])) else $error("ring max changed");
    ring_noflag_a: assert property (CFG[0].ring_mode |->
        !STATUS[0].overflow && !STATUS[0].underflow) else $error("ring flag set");
    cmp_refuse_a: assert property (CMP_START[0] && !CMP_STOP[0] && CFG[0].ring_mode
        && CMP_TABLE_MAX > eff_max |=> CMP_REFUSED) else $error("start not refused");
    cmp_accept_a: assert property (CMP_START[0] && !CMP_STOP[0] && !(CFG[0].ring_mode
        && CMP_TABLE_MAX > eff_max) |=> STATUS[0].cmp_active && !CMP_REFUSED)
        else $error("start not taken");
    halt_hold_a: assert property ((STATUS[0].overflow || STATUS[0].underflow)
        && !CFG[0].ring_mode && !COUNT_WR[0] && !RING_MAX_WR[0] && !SCAN_START
        |=> $stable({STATUS[0].overflow, STATUS[0].underflow})) else $error("halt lost");
    freq_sat_a: assert property (FREQ_ACK |-> FREQ_DATA <=
        ((CFG[0].input_mode == MODE_DIFF_4X) ? FREQ_MAX_DIFF : FREQ_MAX_OTHER))
        else $error("frequency above max");
    rot_time_a: assert property (ROT_REQ && !ROT_BUSY |=> rot_run)
        else $error("rotation timing");
endmodule : hspc_counter_assertions
bind hspc_counter hspc_counter_assertions #(.N_CNT(N_CNT)) u_chk (.*);

// ### verification/test_high_speed_pulse_counter.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_high_speed_pulse_counter;
    import hspc_pkg::*;
    int errors = 0;
    int n_checks = 0;
    int unsigned n, m, p;
    logic CLK = 0, RST_N = 0, SCAN_START = 0, IO_REFRESH = 0, PV_RD_REQ = 0, FREQ_REQ = 0;
    logic ROT_REQ = 0, ROT_TOTAL = 1, RING_MAX_REFUSED, CMP_REFUSED, PV_RD_ACK;
    logic FREQ_ACK, ROT_DONE, ROT_BUSY;
    logic [1:0] PV_RD_SEL = 0;
    logic [3:0] PHASE_A, PHASE_B, INDEX_Z = 0, INT_IN = 0, COUNTER_RESET_BITS = 0;
    logic [3:0] RING_MAX_WR = 0, COUNT_WR = 0, CMP_START = 0, CMP_STOP = 0;
    logic [31:0] RING_MAX_DATA = 0, COUNT_WR_DATA = 0, CMP_TABLE_MAX = 0, PULSES_PER_ROT = 1;
    logic [31:0] PV_RD_DATA, FREQ_DATA, ROT_DATA;
    logic [3:0][31:0] RING_MAX;
    hspc_cfg_type [3:0] CFG = '0;
    hspc_stat_type [3:0] STATUS;
    hspc_words_type [3:0] COUNT_WORDS, LATCHED_WORDS;
    always #50 CLK = ~CLK;
    // Short frequency window keeps the run brief
    hspc_counter #(.WINDOW_CYCLES(100)) dut (.*);
    hspc_pulse_src src (.CLK(CLK), .PHASE_A(PHASE_A), .PHASE_B(PHASE_B));
    function automatic logic [31:0] eff(input logic [31:0] v);
        return (v == 32'h0) ? 32'hFFFF_FFFF : v;
    endfunction : eff
    task automatic act(input int k, input logic [31:0] v);
        @(posedge CLK);
        case (k)
            0: {COUNT_WR[0], COUNT_WR_DATA} <= {1'h1, v};
            1: {RING_MAX_WR[0], RING_MAX_DATA} <= {1'h1, v};
            2: {CMP_START[0], CMP_TABLE_MAX} <= {1'h1, v};
            3: SCAN_START <= 1'h1;
            4: {IO_REFRESH, PV_RD_REQ} <= 2'h3;
            5: {ROT_REQ, PULSES_PER_ROT} <= {1'h1, v};
            default: FREQ_REQ <= 1'h1;
        endcase
        @(posedge CLK);
        {COUNT_WR, RING_MAX_WR, CMP_START, CMP_STOP} <= 16'h0;
        {SCAN_START, IO_REFRESH, PV_RD_REQ, ROT_REQ, FREQ_REQ} <= 5'h0;
        #1;
    endtask : act
    task automatic rd(input logic [31:0] e);
        act(4, 32'h0);
        `CHK(PV_RD_DATA, e)
        `CHK(COUNT_WORDS[0], e)
        `CHK(PV_RD_ACK, 1'h1)
    endtask : rd
    task complete_run;
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial
    begin
        #2_000_000;
        errors++;
        complete_run();
    end
    initial
    begin
        void'($urandom(29329));
        repeat (8) @(posedge CLK);
        RST_N <= 1'h1;
        CFG[0].reset_sw_only <= 1'h1;
        CFG[0].input_mode <= MODE_PULSE_DIR;
        repeat (3) @(posedge CLK);
        n = $urandom % 6 + 2;
        src.run(n, 1'h1);
        rd(n);
        src.run(1, 1'h0);
        rd(n - 1);
        act(0, LIN_UPPER);
        src.run(2, 1'h1);
        rd(LIN_UPPER);
        `CHK(STATUS[0].overflow, 1'h1)
        @(posedge CLK) COUNTER_RESET_BITS[0] <= 1'h1;
        act(3, 32'h0);
        rd(32'h0);
        `CHK(STATUS[0].overflow, 1'h0)
        src.run(1, 1'h1);
        @(posedge CLK) COUNTER_RESET_BITS[0] <= 1'h0;
        @(posedge CLK) COUNTER_RESET_BITS[0] <= 1'h1;
        act(3, 32'h0);
        rd(32'h1);
        @(posedge CLK) COUNTER_RESET_BITS[0] <= 1'h0;
        act(3, 32'h0);
        @(posedge CLK) CFG[0].ring_mode <= 1'h1;
        m = $urandom % 8 + 2;
        act(1, m);
        rd(32'h0);
        src.run(1, 1'h0);
        rd(m);
        `CHK(STATUS[0].count_up, 1'h0)
        src.run(2, 1'h1);
        rd(32'h1);
        act(1, 32'h0);
        src.run(1, 1'h0);
        rd(eff(32'h0));
        act(1, m);
        act(2, m + 1);
        `CHK(CMP_REFUSED, 1'h1)
        act(2, m);
        act(1, 32'h5);
        `CHK(RING_MAX_REFUSED, 1'h1)
        @(posedge CLK) COUNTER_RESET_BITS[0] <= 1'h1;
        act(3, 32'h0);
        `CHK(STATUS[0].cmp_active, 1'h0)
        src.run(2, 1'h1);
        @(posedge CLK) INT_IN[0] <= 1'h1;
        repeat (4) @(posedge CLK);
        INT_IN[0] <= 1'h0;
        repeat (4) @(posedge CLK);
        `CHK(LATCHED_WORDS[0], 32'h2)
        p = $urandom % 3 + 1;
        act(5, p);
        repeat (40) @(posedge CLK);
        `CHK(ROT_DATA, 32'h2 / p)
        // Index method: a bit raised between scans must not arm until the next scan
        {CFG[0].reset_sw_only, CFG[0].cmp_continue, COUNTER_RESET_BITS[0]} <= 3'h2;
        act(2, m);
        act(3, 32'h0);
        @(posedge CLK) COUNTER_RESET_BITS[0] <= 1'h1;
        for (int k = 0; k < 2; k++)
        begin
            `CHK(STATUS[0].index_armed, k[0])
            @(posedge CLK) INDEX_Z[0] <= 1'h1;
            repeat (3) @(posedge CLK);
            INDEX_Z[0] <= 1'h0;
            rd(k ? 32'h0 : 32'h2);
            act(3, 32'h0);
        end
        `CHK(STATUS[0].cmp_active, 1'h1)
        src.run(40, 1'h1);
        act(6, 32'h0);
        `CHK(FREQ_DATA inside {32'h10, 32'h11}, 1'h1)
        complete_run();
    end
endmodule : test_high_speed_pulse_counter
